// >>> hdl/cold_load_pkg.sv
// shared constants and types of the cold load pick-up timer logic
package cold_load_pkg;
   // wishbone register byte offsets
   localparam logic [7:0] OFS_CONTROL     = 8'h00;
   localparam logic [7:0] OFS_LOW_THR     = 8'h04;
   localparam logic [7:0] OFS_HIGH_THR    = 8'h08;
   localparam logic [7:0] OFS_OVER_THR    = 8'h0c;
   localparam logic [7:0] OFS_START_DELAY = 8'h10;
   localparam logic [7:0] OFS_MAX_INRUSH  = 8'h14;
   localparam logic [7:0] OFS_MIN_HOLD    = 8'h18;
   localparam logic [7:0] OFS_STATUS      = 8'h1c;

   // field positions
   localparam int CTRL_ENABLE_BIT = 0;

   // currents in hundredths of nominal current
   localparam int CUR_W = 16;
   localparam int TMR_W = 19;
   localparam logic [CUR_W-1:0] LOW_THR_RST  = 16'h0014;
   localparam logic [CUR_W-1:0] HIGH_THR_RST = 16'h0078;
   localparam logic [CUR_W-1:0] OVER_THR_RST = 16'h00c8;

   // hysteresis: a flag clears below 97/100 of its setting
   localparam logic [23:0] HYS_NUM = 24'h000061;
   localparam logic [23:0] HYS_DEN = 24'h000064;

   // program cycle and timer settings, times in their own units
   localparam int TICK_US        = 5000;
   localparam int START_DELAY_MS = 10000;
   localparam int MAX_INRUSH_MS  = 30000;
   localparam int MIN_HOLD_MS    = 40;
   localparam int START_TICKS = START_DELAY_MS * 1000 / TICK_US;
   localparam int MAX_TICKS   = MAX_INRUSH_MS * 1000 / TICK_US;
   localparam int MIN_TICKS   = MIN_HOLD_MS * 1000 / TICK_US;
   localparam logic [TMR_W-1:0] START_RST = TMR_W'(START_TICKS);
   localparam logic [TMR_W-1:0] MAX_RST   = TMR_W'(MAX_TICKS);
   localparam logic [TMR_W-1:0] MIN_RST   = TMR_W'(MIN_TICKS);

   // condition status codes
   localparam logic [2:0] COND_NORMAL  = 3'h0;
   localparam logic [2:0] COND_LOW     = 3'h1;
   localparam logic [2:0] COND_OVER    = 3'h2;
   localparam logic [2:0] COND_ACTIVE  = 3'h3;
   localparam logic [2:0] COND_BLOCKED = 3'h4;

   typedef logic [2:0][CUR_W-1:0] phase_current_t;

   typedef enum logic [2:0] {
      S_NORMAL, S_LOW, S_BLOCKED, S_WAIT, S_HOLD, S_INRUSH
   } fsm_t;

   typedef struct packed {
      fsm_t             fsm;
      logic             blk;
      logic [8:0]       hys;
      logic [TMR_W-1:0] tcnt;
      logic [TMR_W-1:0] mcnt;
      logic             mdone;
      logic             enable;
      logic [CUR_W-1:0] low_thr;
      logic [CUR_W-1:0] high_thr;
      logic [CUR_W-1:0] over_thr;
      logic [TMR_W-1:0] start_delay;
      logic [TMR_W-1:0] max_inrush;
      logic [TMR_W-1:0] min_hold;
      logic             act;
      logic             blkd;
      logic [2:0]       cond;
      logic             ack;
      logic [31:0]      rdata;
   } state_t;
endpackage

// >>> hdl/cold_load_timer.sv
// cold load pick-up detector: thresholds, timers, blocking, wishbone regs
`timescale 1ns/10ps
module cold_load_timer (
   input  wire logic                        mclk,
   input  wire logic                        reset,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [7:0]                  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output      logic [31:0]                 wb_dat_o,
   output      logic                        wb_ack_o,
   input  wire logic                        program_tick,
   input  wire cold_load_pkg::phase_current_t measured_current,
   input  wire logic                        block_in,
   output      logic                        cold_load_active,
   output      logic                        blocked,
   output      logic [2:0]                  condition_status
);
   cold_load_pkg::state_t st;
   cold_load_pkg::state_t next_st;
   logic [8:0]            next_hys;
   logic [2:0][cold_load_pkg::CUR_W-1:0] thr;

   assign thr = {st.over_thr, st.high_thr, st.low_thr};

   // flag index is threshold*3 + phase; 0 low, 1 high, 2 over
   genvar g;
   generate
      for (g = 0; g < 9; g++) begin : g_hys
         logic        above;
         logic        under;
         logic [23:0] m100;
         logic [23:0] t97;
         assign m100  = 24'(measured_current[g % 3])
                        * cold_load_pkg::HYS_DEN;
         assign t97   = 24'(thr[g / 3]) * cold_load_pkg::HYS_NUM;
         assign above = measured_current[g % 3] > thr[g / 3];
         assign under = m100 < t97;
         // set on exceeding, clear only below 97 percent
         assign next_hys[g] = above ? 1'b1 :
                              (under ? 1'b0 : st.hys[g]);
      end
   endgenerate

   // conditions as seen after this tick's update
   logic lo_now;
   logic hi_now;
   logic ov_now;
   assign lo_now = ~|next_hys[2:0];
   assign hi_now = &next_hys[5:3];
   assign ov_now = |next_hys[8:6];

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      logic [cold_load_pkg::TMR_W-1:0] c;
      logic                            req;
      logic                            act_st;
      logic [31:0]                     w;
      c = '0;
      w = '0;
      next_st = st;
      req = wb_cyc_i & wb_stb_i & ~st.ack;
      next_st.ack = req;
      next_st.rdata = 32'h0;
      act_st = (st.fsm == cold_load_pkg::S_WAIT)
               || (st.fsm == cold_load_pkg::S_HOLD)
               || (st.fsm == cold_load_pkg::S_INRUSH);
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            cold_load_pkg::OFS_CONTROL:
               next_st.rdata = {31'h0, st.enable};
            cold_load_pkg::OFS_LOW_THR:
               next_st.rdata = {16'h0, st.low_thr};
            cold_load_pkg::OFS_HIGH_THR:
               next_st.rdata = {16'h0, st.high_thr};
            cold_load_pkg::OFS_OVER_THR:
               next_st.rdata = {16'h0, st.over_thr};
            cold_load_pkg::OFS_START_DELAY:
               next_st.rdata = {13'h0, st.start_delay};
            cold_load_pkg::OFS_MAX_INRUSH:
               next_st.rdata = {13'h0, st.max_inrush};
            cold_load_pkg::OFS_MIN_HOLD:
               next_st.rdata = {13'h0, st.min_hold};
            cold_load_pkg::OFS_STATUS:
               next_st.rdata = {20'h0, st.mdone, ~|st.hys[2:0],
                                &st.hys[5:3], |st.hys[8:6],
                                st.fsm, st.cond, st.blkd,
                                st.act};
            default:
               next_st.rdata = 32'h0;
         endcase
      end
      if (req && wb_we_i) begin
         unique case (wb_adr_i)
            cold_load_pkg::OFS_CONTROL: begin
               w = merge({31'h0, st.enable}, wb_dat_i, wb_sel_i);
               next_st.enable = w[cold_load_pkg::CTRL_ENABLE_BIT];
            end
            cold_load_pkg::OFS_LOW_THR: begin
               w = merge({16'h0, st.low_thr}, wb_dat_i, wb_sel_i);
               next_st.low_thr = w[15:0];
            end
            cold_load_pkg::OFS_HIGH_THR: begin
               w = merge({16'h0, st.high_thr}, wb_dat_i, wb_sel_i);
               next_st.high_thr = w[15:0];
            end
            cold_load_pkg::OFS_OVER_THR: begin
               w = merge({16'h0, st.over_thr}, wb_dat_i, wb_sel_i);
               next_st.over_thr = w[15:0];
            end
            cold_load_pkg::OFS_START_DELAY: begin
               w = merge({13'h0, st.start_delay}, wb_dat_i, wb_sel_i);
               next_st.start_delay = w[18:0];
            end
            cold_load_pkg::OFS_MAX_INRUSH: begin
               w = merge({13'h0, st.max_inrush}, wb_dat_i, wb_sel_i);
               next_st.max_inrush = w[18:0];
            end
            cold_load_pkg::OFS_MIN_HOLD: begin
               w = merge({13'h0, st.min_hold}, wb_dat_i, wb_sel_i);
               next_st.min_hold = w[18:0];
            end
            default: ;
         endcase
      end

      // all decisions happen once per program cycle
      if (program_tick) begin
         next_st.blk = block_in;
         next_st.hys = next_hys;
         // release paths win over everything else in active states
         if (act_st && (block_in || ov_now)) begin
            next_st.fsm = cold_load_pkg::S_NORMAL;
         end else begin
            unique case (st.fsm)
               cold_load_pkg::S_NORMAL: begin
                  next_st.tcnt = '0;
                  if (lo_now) begin
                     if (st.start_delay == '0) begin
                        next_st.fsm = block_in ?
                           cold_load_pkg::S_BLOCKED :
                           cold_load_pkg::S_WAIT;
                     end else begin
                        next_st.fsm = cold_load_pkg::S_LOW;
                     end
                  end
               end
               cold_load_pkg::S_LOW: begin
                  c = st.tcnt + 1'b1;
                  if (!lo_now) begin
                     next_st.fsm = cold_load_pkg::S_NORMAL;
                  end else if (c >= st.start_delay) begin
                     next_st.fsm = block_in ?
                        cold_load_pkg::S_BLOCKED :
                        cold_load_pkg::S_WAIT;
                  end else begin
                     next_st.tcnt = c;
                  end
               end
               cold_load_pkg::S_BLOCKED: begin
                  // no timing here; left once the low load ends
                  if (!lo_now) begin
                     next_st.fsm = cold_load_pkg::S_NORMAL;
                  end
               end
               cold_load_pkg::S_WAIT: begin
                  next_st.mcnt = '0;
                  next_st.mdone = (st.min_hold == '0);
                  next_st.tcnt = '0;
                  if (hi_now) begin
                     next_st.fsm = cold_load_pkg::S_INRUSH;
                  end else if (!lo_now) begin
                     next_st.fsm = (st.min_hold == '0) ?
                        cold_load_pkg::S_NORMAL :
                        cold_load_pkg::S_HOLD;
                  end
               end
               cold_load_pkg::S_HOLD: begin
                  c = st.mcnt + 1'b1;
                  next_st.tcnt = '0;
                  if (c >= st.min_hold) begin
                     next_st.mdone = 1'b1;
                  end else begin
                     next_st.mcnt = c;
                  end
                  if (hi_now) begin
                     next_st.fsm = cold_load_pkg::S_INRUSH;
                  end else if (c >= st.min_hold || st.mdone) begin
                     next_st.fsm = cold_load_pkg::S_NORMAL;
                  end
               end
               cold_load_pkg::S_INRUSH: begin
                  // min hold keeps running alongside the inrush timer
                  if (st.mcnt + 1'b1 >= st.min_hold) begin
                     next_st.mdone = 1'b1;
                  end else begin
                     next_st.mcnt = st.mcnt + 1'b1;
                  end
                  c = st.tcnt + 1'b1;
                  if (c >= st.max_inrush) begin
                     next_st.fsm = cold_load_pkg::S_NORMAL;
                  end else if (!hi_now) begin
                     // a hold that runs out on this very tick counts
                     next_st.fsm = next_st.mdone ?
                        cold_load_pkg::S_NORMAL :
                        cold_load_pkg::S_HOLD;
                  end else begin
                     next_st.tcnt = c;
                  end
               end
               default: next_st.fsm = cold_load_pkg::S_NORMAL;
            endcase
         end
         if (!st.enable) begin
            next_st.fsm = cold_load_pkg::S_NORMAL;
         end
      end

      next_st.act = (next_st.fsm == cold_load_pkg::S_WAIT)
                    || (next_st.fsm == cold_load_pkg::S_HOLD)
                    || (next_st.fsm == cold_load_pkg::S_INRUSH);
      next_st.blkd = next_st.fsm == cold_load_pkg::S_BLOCKED;
      if (next_st.act) begin
         next_st.cond = cold_load_pkg::COND_ACTIVE;
      end else if (next_st.blkd) begin
         next_st.cond = cold_load_pkg::COND_BLOCKED;
      end else if (|next_st.hys[8:6]) begin
         next_st.cond = cold_load_pkg::COND_OVER;
      end else if (~|next_st.hys[2:0]) begin
         next_st.cond = cold_load_pkg::COND_LOW;
      end else begin
         next_st.cond = cold_load_pkg::COND_NORMAL;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st             <= '0;
         st.fsm         <= cold_load_pkg::S_NORMAL;
         st.enable      <= 1'b1;
         st.low_thr     <= cold_load_pkg::LOW_THR_RST;
         st.high_thr    <= cold_load_pkg::HIGH_THR_RST;
         st.over_thr    <= cold_load_pkg::OVER_THR_RST;
         st.start_delay <= cold_load_pkg::START_RST;
         st.max_inrush  <= cold_load_pkg::MAX_RST;
         st.min_hold    <= cold_load_pkg::MIN_RST;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o         = st.ack;
   assign wb_dat_o         = st.rdata;
   assign cold_load_active = st.act;
   assign blocked          = st.blkd;
   assign condition_status = st.cond;

   a_block_sampled: assert property (
      @(posedge mclk) disable iff (reset)
      !program_tick |=> $stable(st.blk))
      else $error("block sample changed off tick");

   a_act_unblocked: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(cold_load_active) |-> !st.blk && !blocked)
      else $error("activation while blocked");

   a_blocked_only: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(blocked) |-> st.blk && !cold_load_active)
      else $error("blocked raised without block");

   a_block_release: assert property (
      @(posedge mclk) disable iff (reset)
      program_tick && cold_load_active && block_in
      |=> !cold_load_active && !blocked)
      else $error("block did not release activation");

   a_over_release: assert property (
      @(posedge mclk) disable iff (reset)
      program_tick && cold_load_active && ov_now
      |=> !cold_load_active)
      else $error("overcurrent did not release");

   a_inrush_bound: assert property (
      @(posedge mclk) disable iff (reset)
      st.fsm == cold_load_pkg::S_INRUSH
      |-> st.tcnt < st.max_inrush)
      else $error("inrush timer passed its limit");

   a_status_code: assert property (
      @(posedge mclk) disable iff (reset)
      (cold_load_active |-> condition_status == 3'h3)
      and (blocked |-> condition_status == 3'h4))
      else $error("condition status mismatch");

   a_start_source: assert property (
      @(posedge mclk) disable iff (reset)
      $rose(cold_load_active) |-> $past(program_tick)
      && (st.start_delay == '0 || $past(st.fsm)
          == cold_load_pkg::S_LOW))
      else $error("activation without full low period");

   a_hold_bound: assert property (
      @(posedge mclk) disable iff (reset)
      st.fsm == cold_load_pkg::S_HOLD |-> st.mcnt < st.min_hold)
      else $error("min hold counter passed its limit");
endmodule

// >>> bench/front_end_model.sv
// stand-in for the measurement front end and the blocking matrix
`timescale 1ns/10ps
module front_end_model (
   input  wire logic                          mclk,
   input  wire logic                          reset,
   input  wire logic                          req,
   input  wire cold_load_pkg::phase_current_t cur_set,
   input  wire logic                          blk_set,
   output      logic                          program_tick,
   output      cold_load_pkg::phase_current_t measured_current,
   output      logic                          block_in
);
   int seed = 32'hf3ab;

   initial begin
      program_tick = 1'b0;
      measured_current = '0;
      block_in = 1'b0;
   end

   // one program cycle per request, so the bench knows every tick
   always @(posedge mclk) begin
      if (!reset && req) begin
         program_tick     <= 1'b1;
         measured_current <= cur_set;
         block_in         <= blk_set;
      end else begin
         // junk between ticks: a stale value would hide sampling slips
         program_tick     <= 1'b0;
         measured_current <= 48'({$random(seed), $random(seed)});
         block_in         <= 1'($random(seed));
      end
   end
endmodule

// >>> bench/testbench.sv
// self-checking bench of the cold load pick-up timer logic
`timescale 1ns/10ps
module testbench;
   logic                          mclk     = 1'b0;
   logic                          reset    = 1'b1;
   logic                          wb_cyc_i = 1'b0;
   logic                          wb_stb_i = 1'b0;
   logic                          wb_we_i  = 1'b0;
   logic [7:0]                    wb_adr_i = 8'h00;
   logic [3:0]                    wb_sel_i = 4'h0;
   logic [31:0]                   wb_dat_i = 32'h0;
   logic [31:0]                   wb_dat_o;
   logic                          wb_ack_o;
   logic                          program_tick;
   logic                          block_in;
   logic                          req      = 1'b0;
   logic                          blk_set  = 1'b0;
   cold_load_pkg::phase_current_t measured_current;
   cold_load_pkg::phase_current_t cur_set  = '0;
   logic                          cold_load_active;
   logic                          blocked;
   logic [2:0]                    condition_status;
   logic [31:0]                   rd;
   int                            fail_count = 0;
   int                            comparisons = 0;
   int                            cycles = 0;
   int                            seed = 32'hf3ab;
   // reference settings, phase flags and timer state
   int lt = 20, ht = 120, ot = 200, nd = 2000, mx = 6000, mn = 8, en = 1;
   int ms = 0, sc = 0, lc = 0, ic = 0;
   int lf[3], hf[3], of[3];

   cold_load_timer i_cold_load_timer (
      .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .program_tick(program_tick), .measured_current(measured_current),
      .block_in(block_in), .cold_load_active(cold_load_active),
      .blocked(blocked), .condition_status(condition_status));
   front_end_model i_front_end_model (
      .mclk(mclk), .reset(reset), .req(req), .cur_set(cur_set),
      .blk_set(blk_set), .program_tick(program_tick),
      .measured_current(measured_current), .block_in(block_in));

   initial forever #25 mclk = ~mclk;

   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      // ack and read data are taken at a rising edge only
      @(posedge mclk);
      while (wb_ack_o !== 1'b1) begin
         n++;
         @(posedge mclk);
      end
      chk(32'(n), 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] adr, input int exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, 32'(exp));
   endtask

   task automatic setreg(input logic [7:0] adr, input int v);
      wb(1'b1, adr, 32'(v));
      case (adr)
         cold_load_pkg::OFS_CONTROL:     en = v;
         cold_load_pkg::OFS_START_DELAY: nd = v;
         cold_load_pkg::OFS_MAX_INRUSH:  mx = v;
         cold_load_pkg::OFS_MIN_HOLD:    mn = v;
         default:                        en = en;
      endcase
      rdchk(adr, v);
   endtask

   function automatic logic [2:0] cond();
      if (ms >= 3) return 3'h3;
      if (ms == 2) return 3'h4;
      // outside activation and blocking the status follows the measured level
      if (of[0] | of[1] | of[2]) return 3'h2;
      return (lf[0] | lf[1] | lf[2]) ? 3'h0 : 3'h1;
   endfunction

   function automatic int hy(int f, int c, int t);
      if (c > t) return 1;
      if (100 * c < 97 * t) return 0;
      return f;
   endfunction

   // ms: 0 normal, 1 low count, 2 blocked, 3 active low, 4 hold, 5 inrush
   task automatic ref_tick(input int c[3], input bit b);
      bit low, high, over;
      for (int p = 0; p < 3; p++) begin
         lf[p] = hy(lf[p], c[p], lt);
         hf[p] = hy(hf[p], c[p], ht);
         of[p] = hy(of[p], c[p], ot);
      end
      low  = !(lf[0] | lf[1] | lf[2]);
      high = hf[0] & hf[1] & hf[2];
      over = of[0] | of[1] | of[2];
      if (!en)
         ms = 0;
      else if (ms >= 3) begin
         if (over || b)
            ms = 0;
         else if (ms > 3 || !low) begin
            lc = (ms == 3) ? 0 : lc + 1;
            ic = (ms == 5) ? ic + 1 : 0;
            if (high)
               ms = (ic >= mx) ? 0 : 5;
            else
               ms = (lc >= mn) ? 0 : 4;
         end
      end else if (ms == 2) begin
         if (!low) ms = 0;
      end else if (ms == 1 && !low)
         ms = 0;
      else if (ms == 1 || low) begin
         sc = (ms == 1) ? sc + 1 : 0;
         ms = (sc >= nd) ? (b ? 2 : 3) : 1;
      end
   endtask

   task automatic step(input int c0, input int c1, input int c2,
                       input bit b, input int n);
      int c[3];
      repeat (n) begin
         c[0] = c0 + {$random(seed)} % 5;
         c[1] = c1 + {$random(seed)} % 5;
         c[2] = c2 + {$random(seed)} % 5;
         @(posedge mclk);
         cur_set <= {16'(c[2]), 16'(c[1]), 16'(c[0])};
         blk_set <= b;
         req     <= 1'b1;
         @(posedge mclk);
         req     <= 1'b0;
         @(posedge mclk);
         ref_tick(c, b);
         @(negedge mclk);
         chk({27'h0, cold_load_active, blocked, condition_status},
             {27'h0, ms >= 3, ms == 2, cond()});
      end
   endtask

   task automatic stat;
      wb(1'b0, cold_load_pkg::OFS_STATUS, 32'h0);
      chk(rd & 32'h1f, {27'h0, cond(), ms == 2, ms >= 3});
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      chk({27'h0, cold_load_active, blocked, condition_status}, 0);
      rdchk(cold_load_pkg::OFS_CONTROL, 1);
      rdchk(cold_load_pkg::OFS_LOW_THR, 20);
      rdchk(cold_load_pkg::OFS_HIGH_THR, 120);
      rdchk(cold_load_pkg::OFS_OVER_THR, 200);
      rdchk(cold_load_pkg::OFS_START_DELAY, 10000 / 5);
      rdchk(cold_load_pkg::OFS_MAX_INRUSH, 30000 / 5);
      rdchk(cold_load_pkg::OFS_MIN_HOLD, 40 / 5);
      rdchk(8'h20, 0);
      wb(1'b1, cold_load_pkg::OFS_STATUS, 32'hffffffff);
      stat();
      setreg(cold_load_pkg::OFS_START_DELAY, 3);
      setreg(cold_load_pkg::OFS_MAX_INRUSH, 4);
      setreg(cold_load_pkg::OFS_MIN_HOLD, 2);
      step(60, 60, 60, 0, 2);
      step(5, 5, 5, 0, 2);
      step(60, 60, 60, 0, 1);
      step(5, 5, 60, 0, 5);
      step(5, 5, 5, 0, 4);
      step(150, 150, 150, 0, 2);
      step(117, 117, 117, 0, 3);
      setreg(cold_load_pkg::OFS_MIN_HOLD, 4);
      step(5, 5, 5, 0, 4);
      step(60, 60, 60, 0, 1);
      step(150, 150, 150, 0, 1);
      step(60, 60, 60, 0, 3);
      step(5, 5, 5, 0, 4);
      step(60, 60, 60, 0, 1);
      step(150, 150, 150, 0, 3);
      step(60, 60, 60, 0, 1);
      step(5, 5, 5, 0, 4);
      step(150, 150, 60, 0, 1);
      step(150, 150, 250, 0, 1);
      step(5, 5, 5, 0, 4);
      step(5, 5, 5, 1, 1);
      step(5, 5, 5, 1, 4);
      stat();
      step(60, 60, 60, 0, 1);
      setreg(cold_load_pkg::OFS_MIN_HOLD, 0);
      setreg(cold_load_pkg::OFS_START_DELAY, 0);
      step(5, 5, 5, 0, 1);
      step(60, 60, 60, 0, 1);
      setreg(cold_load_pkg::OFS_CONTROL, 0);
      step(5, 5, 5, 0, 3);
      setreg(cold_load_pkg::OFS_CONTROL, 1);
      step(5, 5, 5, 0, 1);
      summarize();
   end
endmodule
